/* File: design/pcu_pkg.sv */
// Purpose: shared constants for the program counter unit
// Assumes: 32-bit APB, word-aligned registers, 200 MHz pclk
// Notes: register offsets are byte addresses
package pcu_pkg;
   localparam int PC_W = 21;
   localparam int SP_W = 5;
   localparam int STACK_DEPTH = 31;
   localparam int INSTR_W = 16;
   localparam int FLASH_BYTES = 16384;
   localparam logic [PC_W-1:0] PC_STEP = 21'h00002;
   localparam logic [PC_W-1:0] RESET_VECTOR = 21'h00000;
   localparam logic [PC_W-1:0] HIGH_IRQ_VECTOR = 21'h00008;
   localparam logic [PC_W-1:0] LOW_IRQ_VECTOR = 21'h00018;
   localparam logic [7:0] REG_PC_LOW_BYTE = 8'h00;
   localparam logic [7:0] REG_HIGH_LATCH = 8'h04;
   localparam logic [7:0] REG_UPPER_LATCH = 8'h08;
   localparam logic [7:0] REG_CTRL = 8'h0C;
   localparam logic [7:0] REG_STACK_STAT = 8'h10;
   localparam logic [7:0] REG_TOS = 8'h14;
   localparam int CTRL_RUN = 0;
   localparam int CTRL_HIGH_EN = 1;
   localparam int CTRL_LOW_EN = 2;
   localparam int STAT_UNF = 6;
   localparam int STAT_FULL = 7;
   localparam int UPPER_W = 5;
   // branch kinds on the decode port
   typedef enum logic [2:0] {
      PCU_BR_CALL = 3'b001,
      PCU_BR_RELATIVE_CALL_OP = 3'b010,
      PCU_BR_JUMP = 3'b100
   } pcu_branch_t;
endpackage

/* File: design/pcu_fetch_filter.sv */
// Purpose: registers fetched instruction, zeroing unimplemented space
// Assumes: program memory read data is valid for the presented address
// Notes: zero decodes as a no-operation
`timescale 1ns/10ps
module pcu_fetch_filter #(
   parameter int IMPL_BYTES = pcu_pkg::FLASH_BYTES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic fetch_req,
   input wire logic [pcu_pkg::PC_W-1:0] fetch_addr,
   input wire logic [pcu_pkg::INSTR_W-1:0] mem_rdata,
   output logic [pcu_pkg::INSTR_W-1:0] instr,
   output logic instr_valid
);
   import pcu_pkg::*;

   localparam logic [PC_W-1:0] IMPL_LIMIT = PC_W'(IMPL_BYTES);

   wire logic in_flash;
   wire logic [INSTR_W-1:0] next_instr;

   assign in_flash = fetch_addr < IMPL_LIMIT;
   assign next_instr = in_flash ? mem_rdata : '0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         instr <= '0;
         instr_valid <= 1'b0;
      end else begin
         instr <= next_instr;
         instr_valid <= fetch_req;
      end
   end
endmodule // pcu_fetch_filter

/* File: design/pcu_return_stack.sv */
// Purpose: 31-entry return address stack with pointer and flags
// Assumes: push and pop never in the same cycle
// Notes: slot 0 holds no storage; flags are sticky
`timescale 1ns/10ps
module pcu_return_stack #(
   parameter int DEPTH = pcu_pkg::STACK_DEPTH
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic push,
   input wire logic [pcu_pkg::PC_W-1:0] push_value,
   input wire logic pop,
   input wire logic clr_full,
   input wire logic clr_unf,
   output logic [pcu_pkg::PC_W-1:0] tos,
   output logic [pcu_pkg::SP_W-1:0] return_stack_pointer,
   output logic stack_full,
   output logic stack_unf
);
   import pcu_pkg::*;

   localparam logic [SP_W-1:0] SP_TOP = SP_W'(DEPTH);
   localparam logic [SP_W-1:0] SP_ONE = 5'h01;

   logic [PC_W-1:0] slots [1:DEPTH];
   wire logic at_top;
   wire logic at_bottom;
   wire logic [SP_W-1:0] sp_up;

   assign at_top = return_stack_pointer == SP_TOP;
   assign at_bottom = return_stack_pointer == '0;
   assign sp_up = return_stack_pointer + SP_ONE;
   assign tos = at_bottom ? '0 : slots[return_stack_pointer];

   always_ff @(posedge pclk) begin
      if (push && !at_top) begin
         slots[sp_up] <= push_value;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         return_stack_pointer <= '0;
      end else if (push && !at_top) begin
         return_stack_pointer <= sp_up;
      end else if (pop && !at_bottom) begin
         return_stack_pointer <= return_stack_pointer - SP_ONE;
      end
   end

   // set wins over software clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stack_full <= 1'b0;
         stack_unf <= 1'b0;
      end else begin
         stack_full <= (push && (at_top || sp_up == SP_TOP))
                       || (stack_full && !clr_full);
         stack_unf <= (pop && at_bottom) || (stack_unf && !clr_unf);
      end
   end
endmodule // pcu_return_stack

/* File: design/pcu_program_counter.sv */
// Purpose: 21-bit fetch program counter with holding latches and vectors
// Assumes: core control inputs are on pclk; APB slave for registers
// Notes: priority is interrupt, return, branch, low-byte write, advance
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/10ps
module pcu_program_counter (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic fetch_ready,
   input wire logic [pcu_pkg::INSTR_W-1:0] prog_rdata,
   output logic [pcu_pkg::PC_W-1:0] prog_addr,
   output logic [pcu_pkg::INSTR_W-1:0] instr,
   output logic instr_valid,
   input wire logic branch_valid,
   input wire logic [2:0] branch_kind,
   input wire logic [pcu_pkg::PC_W-1:0] branch_target,
   input wire logic return_valid,
   input wire logic wake_irq_high,
   input wire logic wake_irq_low
);
   import pcu_pkg::*;

   //--------------------------------------------------------------
   // state
   //--------------------------------------------------------------
   logic [PC_W-1:0] pc;
   logic [7:0] pc_high_holding_latch;
   logic [UPPER_W-1:0] pc_upper_holding_latch;
   logic run;
   logic high_prio_global_irq_enable;
   logic low_prio_global_irq_enable;
   logic [PC_W-1:0] next_pc;

   wire logic [PC_W-1:0] tos;
   wire logic [SP_W-1:0] return_stack_pointer;
   wire logic stack_full;
   wire logic stack_unf;

   //--------------------------------------------------------------
   // apb decode
   //--------------------------------------------------------------
   wire logic setup;
   wire logic done;
   wire logic wr_done;
   wire logic rd_done;
   wire logic sel_low;
   wire logic sel_high;
   wire logic sel_upper;
   wire logic sel_ctrl;
   wire logic sel_stat;
   wire logic sel_tos;
   wire logic mapped;
   wire logic [31:0] rd_mux;

   assign setup = psel && !penable;
   assign done = psel && penable && pready;
   assign wr_done = done && pwrite && !pslverr;
   assign rd_done = done && !pwrite && !pslverr;
   assign sel_low = paddr == REG_PC_LOW_BYTE;
   assign sel_high = paddr == REG_HIGH_LATCH;
   assign sel_upper = paddr == REG_UPPER_LATCH;
   assign sel_ctrl = paddr == REG_CTRL;
   assign sel_stat = paddr == REG_STACK_STAT;
   assign sel_tos = paddr == REG_TOS;
   assign mapped = sel_low || sel_high || sel_upper || sel_ctrl
                   || sel_stat || sel_tos;

   // only the low byte of the counter is visible
   assign rd_mux = sel_low ? {24'h000000, pc[7:0]}
      : sel_high ? {24'h000000, pc_high_holding_latch}
      : sel_upper ? {27'h0000000, pc_upper_holding_latch}
      : sel_ctrl ? {29'h00000000, low_prio_global_irq_enable,
                    high_prio_global_irq_enable, run}
      : sel_stat ? {24'h000000, stack_full, stack_unf, 1'b0,
                    return_stack_pointer}
      : sel_tos ? {11'h000, tos}
      : 32'h00000000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= setup;
         pslverr <= setup && !mapped;
         prdata <= (setup && !pwrite) ? rd_mux : prdata;
      end
   end

   //--------------------------------------------------------------
   // control and holding latches
   //--------------------------------------------------------------
   wire logic wr_low;
   wire logic rd_low;

   assign wr_low = wr_done && sel_low;
   assign rd_low = rd_done && sel_low;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run <= 1'b0;
         high_prio_global_irq_enable <= 1'b0;
         low_prio_global_irq_enable <= 1'b0;
      end else if (wr_done && sel_ctrl) begin
         run <= pwdata[CTRL_RUN];
         high_prio_global_irq_enable <= pwdata[CTRL_HIGH_EN];
         low_prio_global_irq_enable <= pwdata[CTRL_LOW_EN];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_high_holding_latch <= 8'h00;
         pc_upper_holding_latch <= 5'h00;
      end else if (rd_low) begin
         pc_high_holding_latch <= pc[15:8];
         pc_upper_holding_latch <= pc[PC_W-1:16];
      end else if (wr_done && sel_high) begin
         pc_high_holding_latch <= pwdata[7:0];
      end else if (wr_done && sel_upper) begin
         pc_upper_holding_latch <= pwdata[UPPER_W-1:0];
      end
   end

   //--------------------------------------------------------------
   // next counter value
   //--------------------------------------------------------------
   wire logic irq_hi;
   wire logic irq_lo;
   wire logic irq_take;
   wire logic is_call;
   wire logic do_push;
   wire logic [PC_W-1:0] pc_plus;
   wire logic [PC_W-1:0] push_value;

   assign irq_hi = wake_irq_high && high_prio_global_irq_enable;
   assign irq_lo = wake_irq_low && low_prio_global_irq_enable;
   assign irq_take = irq_hi || irq_lo;
   assign is_call = branch_valid && (branch_kind == PCU_BR_CALL
                    || branch_kind == PCU_BR_RELATIVE_CALL_OP);
   assign pc_plus = pc + PC_STEP;
   assign do_push = irq_take || (!return_valid && is_call);
   // interrupt saves current counter, call saves the following address
   assign push_value = irq_take ? pc : pc_plus;

   always_comb begin
      next_pc = pc;
      if (irq_take) begin
         next_pc = irq_hi ? HIGH_IRQ_VECTOR : LOW_IRQ_VECTOR;
      end else if (return_valid) begin
         next_pc = tos;
      end else if (branch_valid) begin
         next_pc = branch_target;
      end else if (wr_low) begin
         next_pc = {pc_upper_holding_latch, pc_high_holding_latch,
                    pwdata[7:0]};
      end else if (run && fetch_ready) begin
         next_pc = pc_plus;
      end
      next_pc[0] = 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc <= RESET_VECTOR;
      end else begin
         pc <= next_pc;
      end
   end

   // fetch address leaves on its own port, apart from the data bus
   assign prog_addr = pc;

   //--------------------------------------------------------------
   // submodules
   //--------------------------------------------------------------
   pcu_return_stack u_stack (
      .pclk(pclk),
      .presetn(presetn),
      .push(do_push),
      .push_value(push_value),
      .pop(return_valid && !irq_take),
      .clr_full(wr_done && sel_stat && !pwdata[STAT_FULL]),
      .clr_unf(wr_done && sel_stat && !pwdata[STAT_UNF]),
      .tos(tos),
      .return_stack_pointer(return_stack_pointer),
      .stack_full(stack_full),
      .stack_unf(stack_unf)
   );

   pcu_fetch_filter u_fetch (
      .pclk(pclk),
      .presetn(presetn),
      .fetch_req(run && fetch_ready),
      .fetch_addr(pc),
      .mem_rdata(prog_rdata),
      .instr(instr),
      .instr_valid(instr_valid)
   );
endmodule // pcu_program_counter

/* File: testbench/pcu_prog_mem_model.sv */
// Purpose: program memory seen from the fetch port
// Assumes: data answers the presented address in the same cycle
// Notes: stall holds off fetches; word data never reads zero
`timescale 1ns/10ps
module pcu_prog_mem_model (
   input wire logic stall,
   input wire logic [pcu_pkg::PC_W-1:0] prog_addr,
   output logic fetch_ready,
   output logic [pcu_pkg::INSTR_W-1:0] prog_rdata
);
   import pcu_pkg::*;
   assign fetch_ready = !stall;
   assign prog_rdata = {prog_addr[15:1], 1'b1};
endmodule // pcu_prog_mem_model

/* File: testbench/pcu_program_counter_chk.sv */
// Purpose: port checks of the program counter unit
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bound from the testbench top file
`timescale 1ns/10ps
module pcu_program_counter_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic fetch_ready,
   input wire logic [pcu_pkg::INSTR_W-1:0] prog_rdata,
   input wire logic [pcu_pkg::PC_W-1:0] prog_addr,
   input wire logic [pcu_pkg::INSTR_W-1:0] instr,
   input wire logic instr_valid,
   input wire logic branch_valid,
   input wire logic [pcu_pkg::PC_W-1:0] branch_target,
   input wire logic return_valid,
   input wire logic wake_irq_high,
   input wire logic wake_irq_low
);
   import pcu_pkg::*;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire ctl = branch_valid | return_valid | wake_irq_high | wake_irq_low;
   wire acc = psel & penable;
   wire lwr = acc & pready & pwrite & (paddr == REG_PC_LOW_BYTE);
   sequence s_setup; psel && !penable; endsequence
   sequence s_ack; pready ##1 !pready; endsequence
   property p_ack; s_setup |=> s_ack; endproperty
   a_ack: assert property (p_ack) else $error("ready not one cycle");
   property p_err; pready && paddr > 8'h14 |-> pslverr; endproperty
   a_err: assert property (p_err) else $error("unmapped not refused");
   property p_bit0; prog_addr[0] == 1'b0; endproperty
   a_bit0: assert property (p_bit0) else $error("pc bit 0 set");
   property p_rst; $rose(presetn) |-> prog_addr == RESET_VECTOR; endproperty
   a_rst: assert property (p_rst) else $error("pc not at reset");
   property p_adv;
      instr_valid && !$past(ctl | acc) |->
         prog_addr == $past(prog_addr) + PC_STEP;
   endproperty
   a_adv: assert property (p_adv) else $error("bad advance");
   property p_br;
      branch_valid && !wake_irq_high && !wake_irq_low && !return_valid |=>
         prog_addr == ($past(branch_target) & 21'h1FFFFE);
   endproperty
   a_br: assert property (p_br) else $error("bad branch load");
   property p_vec;
      prog_addr == LOW_IRQ_VECTOR && $past(prog_addr) != LOW_IRQ_VECTOR
         |-> $past(wake_irq_low | branch_valid | return_valid | acc)
         || instr_valid;
   endproperty
   a_vec: assert property (p_vec) else $error("bad low vector");
   property p_iv; instr_valid |-> $past(fetch_ready); endproperty
   a_iv: assert property (p_iv) else $error("fetch while stalled");
   property p_instr;
      instr_valid |-> instr == (($past(prog_addr) >= FLASH_BYTES) ?
         16'h0000 : $past(prog_rdata));
   endproperty
   a_instr: assert property (p_instr) else $error("bad instr");
   property p_lwr;
      lwr && !ctl |=> prog_addr[7:0] == 8'($past(pwdata) & 32'hFE);
   endproperty
   a_lwr: assert property (p_lwr) else $error("bad low write");
endmodule // pcu_program_counter_chk

/* File: testbench/pcu_program_counter_tb.sv */
// Purpose: directed test of the program counter unit
// Assumes: APB answers with no wait states, core pulses last one cycle
// Notes: expectations worked out from vectors and latch rules
`timescale 1ns/10ps
module pcu_program_counter_tb;
   import pcu_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, stall, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, fetch_ready, instr_valid;
   logic [INSTR_W-1:0] prog_rdata, instr;
   logic [PC_W-1:0] prog_addr, branch_target;
   logic branch_valid, return_valid, wake_irq_high, wake_irq_low;
   logic [2:0] branch_kind;
   int fail_count, cmp_count;
   pcu_program_counter i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fetch_ready(fetch_ready), .prog_rdata(prog_rdata),
      .prog_addr(prog_addr), .instr(instr), .instr_valid(instr_valid),
      .branch_valid(branch_valid), .branch_kind(branch_kind),
      .branch_target(branch_target), .return_valid(return_valid),
      .wake_irq_high(wake_irq_high), .wake_irq_low(wake_irq_low));
   pcu_prog_mem_model i_mem (.stall(stall), .prog_addr(prog_addr),
      .fetch_ready(fetch_ready), .prog_rdata(prog_rdata));
   task automatic stop_test;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, g);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdc(input string n, input logic [7:0] a, input int e);
      apb(1'b0, a, 32'h0);
      chk(n, 32'(e), rd);
   endtask
   task automatic pc_is(input logic [PC_W-1:0] e);
      #1;
      chk("pc", 32'(e), 32'(prog_addr));
   endtask
   task automatic ctl(input logic [2:0] k, input logic [PC_W-1:0] t,
         input logic r, hi, lo);
      @(posedge pclk);
      branch_valid <= |k;
      branch_kind <= k;
      branch_target <= t;
      return_valid <= r;
      wake_irq_high <= hi;
      wake_irq_low <= lo;
      @(posedge pclk);
      branch_valid <= 1'b0;
      return_valid <= 1'b0;
      wake_irq_high <= 1'b0;
      wake_irq_low <= 1'b0;
   endtask
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   initial begin
      #5000;
      fail_count++;
      stop_test;
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {branch_valid, branch_kind, branch_target, return_valid} = '0;
      {wake_irq_high, wake_irq_low, err, fail_count, cmp_count} = '0;
      stall = 1'b1;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      pc_is(RESET_VECTOR);
      rdc("ctrl", REG_CTRL, 0);
      apb(1'b1, REG_CTRL, 32'h6);
      apb(1'b1, REG_HIGH_LATCH, 32'h12);
      apb(1'b1, REG_UPPER_LATCH, 32'hE3);
      rdc("upper", REG_UPPER_LATCH, 32'h03);
      apb(1'b1, REG_PC_LOW_BYTE, 32'h57);
      pc_is(21'h31256);
      rdc("low", REG_PC_LOW_BYTE, 32'h56);
      ctl(PCU_BR_JUMP, 21'h1A4B7, 1'b0, 1'b0, 1'b0);
      pc_is(21'h1A4B6);
      rdc("high", REG_HIGH_LATCH, 32'h12);
      rdc("low", REG_PC_LOW_BYTE, 32'hB6);
      rdc("high", REG_HIGH_LATCH, 32'hA4);
      rdc("upper", REG_UPPER_LATCH, 32'h01);
      ctl(PCU_BR_CALL, 21'h00400, 1'b0, 1'b0, 1'b0);
      rdc("tos", REG_TOS, 32'h1A4B8);
      ctl(PCU_BR_RELATIVE_CALL_OP, 21'h00800, 1'b0, 1'b0, 1'b0);
      rdc("tos", REG_TOS, 32'h402);
      ctl(3'b000, '0, 1'b0, 1'b1, 1'b0);
      pc_is(HIGH_IRQ_VECTOR);
      rdc("tos", REG_TOS, 32'h800);
      ctl(3'b000, '0, 1'b0, 1'b0, 1'b1);
      pc_is(LOW_IRQ_VECTOR);
      ctl(3'b000, '0, 1'b0, 1'b1, 1'b1);
      pc_is(HIGH_IRQ_VECTOR);
      rdc("stat", REG_STACK_STAT, 5);
      ctl(3'b000, '0, 1'b1, 1'b0, 1'b0);
      pc_is(LOW_IRQ_VECTOR);
      apb(1'b1, REG_CTRL, 32'h0);
      ctl(3'b000, '0, 1'b0, 1'b1, 1'b1);
      pc_is(LOW_IRQ_VECTOR);
      rdc("unmapped", 8'h40, 0);
      chk("slverr", 32'h1, 32'(err));
      ctl(PCU_BR_JUMP, 21'h03FF8, 1'b0, 1'b0, 1'b0);
      apb(1'b1, REG_CTRL, 32'h1);
      repeat (3) @(posedge pclk);
      pc_is(21'h03FF8);
      @(posedge pclk);
      stall <= 1'b0;
      repeat (6) @(posedge pclk);
      stall <= 1'b1;
      pc_is(21'h04004);
      chk("instr", 32'h0, 32'(instr));
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      pc_is(RESET_VECTOR);
      rdc("stat", REG_STACK_STAT, 0);
      repeat (31) ctl(PCU_BR_CALL, 21'h00100, 1'b0, 1'b0, 1'b0);
      rdc("stat", REG_STACK_STAT, 32'h9F);
      rdc("tos", REG_TOS, 32'h102);
      apb(1'b1, REG_STACK_STAT, 32'h0);
      rdc("stat", REG_STACK_STAT, 32'h1F);
      repeat (32) ctl(3'b000, '0, 1'b1, 1'b0, 1'b0);
      pc_is(RESET_VECTOR);
      rdc("stat", REG_STACK_STAT, 32'h40);
      stop_test;
   end
endmodule // pcu_program_counter_tb
bind pcu_program_counter pcu_program_counter_chk i_chk (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
   .fetch_ready(fetch_ready), .prog_rdata(prog_rdata),
   .prog_addr(prog_addr), .instr(instr), .instr_valid(instr_valid),
   .branch_valid(branch_valid), .branch_target(branch_target),
   .return_valid(return_valid), .wake_irq_high(wake_irq_high),
   .wake_irq_low(wake_irq_low));
